// ==== backlight_i2c_map.svh ====
// constants, offsets and timing counts of the two-wire slave port
`ifndef BACKLIGHT_I2C_MAP_SVH
`define BACKLIGHT_I2C_MAP_SVH
// Functional notes
// R1 - target only: never drives the clock, never makes start or stop
// R2 - data sampled while clock high; sender changes data only while clock low
// R3 - data change while clock high mid-transfer abandons the transaction
// R4 - bytes are eight bits, msb first, then an acknowledge slot
// R5 - data falling with clock high is start; rising with clock high is stop
// R6 - master makes all starts and stops; bus busy from start to after stop
// R7 - repeated start accepted mid-transfer; next byte is a new address byte
// R8 - ninth clock: transmitter releases data, receiver holds it low through high
// R9 - master clocks every acknowledge; receiver acks all but master's last read byte
// R10 - master marks last read byte by leaving data high in acknowledge clock
// R11 - answers target address 2Ch, address byte 58h write, 59h read
// R12 - first seven bits are address, eighth is direction, one means read
// R13 - address byte acked only on match, then receive or transmit by direction
// R14 - write: address, register index, data bytes, each acked and stored; code nacks and drops a data byte while the write buffer is full
// R15 - index increments after each acknowledged write data byte
// R16 - read: index written, repeated start, read address, then indexed data
// R17 - each master ack during read increments index and sends next register
// R18 - read ends with master nack then stop; device releases data line
// R19 - master ends a write with stop after last acknowledged data byte
// R20 - start or stop resets bit counter and byte state, releases data line
// R21 - clock and data synchronised and glitch filtered before edge detection

// ==========================================
// addressing
`define TARGET_ADDR7 7'h2c
`define ADDR_BYTE_WR 8'h58
`define ADDR_BYTE_RD 8'h59
`define DIR_READ 1'b1

// ==========================================
// framing and timing
`define BYTE_BITS 4'h8
`define TX_LAST_FALL 4'h7
`define GLITCH_TAPS 3
`define FIFO_WIDTH 16
`define FIFO_DEPTH 8
`endif

// ==== backlight_i2c_pkg.sv ====
// types shared by the two-wire slave port
package backlight_i2c_pkg;
    // ==========================================
    // byte state machine, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_WRX = 6'h04,
        ST_ACK = 6'h08,
        ST_TX = 6'h10,
        ST_MACK = 6'h20
    } slave_state_t;
endpackage

// ==== byte_fifo.sv ====
// small fifo with registered read data
`timescale 1ns/1ps
module byte_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t n;
    logic push;
    logic pop;

    // ==========================================
    // next state; depth must be a power of two so pointers wrap freely
    always_comb begin
        n = q;
        push = i_in_valid && (q.cnt < CW'(D));
        pop = (q.cnt != '0) && (!q.ov || i_out_ready);
        if (q.ov && i_out_ready) begin
            n.ov = 1'b0;
        end
        if (pop) begin
            n.od = q.mem[q.rp];
            n.ov = 1'b1;
            n.rp = q.rp + AW'(1);
        end
        if (push) begin
            n.mem[q.wp] = i_in_data;
            n.wp = q.wp + AW'(1);
        end
        n.cnt = q.cnt + CW'(push) - CW'(pop);
    end

    // ==========================================
    // state register, frozen while enable is low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_ce) begin
            q <= n;
        end
    end

    assign o_in_ready = (q.cnt < CW'(D)); // holding side may stall on this
    assign o_out_valid = q.ov;
    assign o_out_data = q.od;
endmodule

// ==== backlight_i2c_slave_port.sv ====
// two-wire slave port of the backlight driver: framing, addressing, byte access
`timescale 1ns/1ps
`include "backlight_i2c_map.svh"
module backlight_i2c_slave_port
    import backlight_i2c_pkg::*;
#(
    parameter int FIFO_W = `FIFO_WIDTH,
    parameter int FIFO_D = `FIFO_DEPTH
) (
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA_O,
    output logic O_SDA_OE,
    output logic O_WR_VALID,
    input wire logic I_WR_READY,
    output logic [7:0] O_WR_INDEX,
    output logic [7:0] O_WR_DATA,
    output logic [7:0] O_RD_INDEX,
    input wire logic [7:0] I_RD_DATA,
    output logic O_BUSY
);
    localparam int T = `GLITCH_TAPS;

    // ==========================================
    // timing budget of the line pipeline
    // pins pass two sync flops and then T filter taps, so every line
    // event is seen about five clocks after the pin has moved
    // both lines share the same pipeline, so their order is kept exactly
    // and a start or stop is never mistaken for a data bit
    // a bus clock phase shorter than the T filter taps is not seen at all:
    // that is the trade for glitch immunity, only slow masters are served
    // the port never stretches the bus clock, so a full write buffer
    // can only be answered by a refused acknowledge
    // read data are taken at the filtered fall, so the register side
    // has at least two clocks after an index step to settle them
    // the index survives a stop, so a read without a fresh index
    // continues where the last transfer left off

    // ==========================================
    // state record
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [T-1:0] scl_hist;
        logic [T-1:0] sda_hist;
        logic scl_f;
        logic sda_f;
        slave_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] index;
        logic have_index;
        logic is_read;
        logic ack_go;
        logic addr_phase;
        logic bump;
        logic sda_o;
        logic sda_oe;
        logic busy;
        logic push;
        logic [15:0] push_data;
    } port_state_t;

    // registered record and its next value; one record keeps the
    // reset and enable handling in a single process
    port_state_t q;
    port_state_t n;
    logic [1:0] rst_pipe;
    logic rst_n;
    logic scl_n;
    logic sda_n;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;

    // ==========================================
    // reset release through two flops; asserts at once, releases on clock
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_pipe <= 2'h0;
        end else if (I_CE) begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ==========================================
    // filtered line levels: a level is taken only once all taps agree
    // a line that flickers between taps keeps its last filtered level
    always_comb begin
        if (&q.scl_hist) begin
            scl_n = 1'b1;
        end else if (~|q.scl_hist) begin
            scl_n = 1'b0;
        end else begin
            scl_n = q.scl_f;
        end
        if (&q.sda_hist) begin
            sda_n = 1'b1;
        end else if (~|q.sda_hist) begin
            sda_n = 1'b0;
        end else begin
            sda_n = q.sda_f;
        end
    end

    // edges of the filtered clock; conditions need clock high on both sides
    assign scl_rise = scl_n && !q.scl_f;
    assign scl_fall = !scl_n && q.scl_f;
    assign start_seen = q.scl_f && scl_n && q.sda_f && !sda_n; // [R5]
    assign stop_seen = q.scl_f && scl_n && !q.sda_f && sda_n; // [R5]

    // ==========================================
    // next state of the whole port
    always_comb begin
        n = q;
        n.push = 1'b0;
        n.sda_o = 1'b0; // open drain: only ever pulls low [R1]
        // two-flop synchronisers feed the glitch filter taps [R21]
        n.scl_sync = {q.scl_sync[0], I_SCL};
        n.sda_sync = {q.sda_sync[0], I_SDA};
        n.scl_hist = {q.scl_hist[T-2:0], q.scl_sync[1]}; // [R21]
        n.sda_hist = {q.sda_hist[T-2:0], q.sda_sync[1]}; // [R21]
        n.scl_f = scl_n;
        n.sda_f = sda_n;

        // conditions win over byte handling in the same cycle
        if (start_seen) begin
            // start or repeated start: next byte is an address [R7] [R20]
            n.st = ST_ADDR;
            n.bit_cnt = 4'h0;
            n.sda_oe = 1'b0;
            n.have_index = 1'b0;
            n.ack_go = 1'b0;
        end else if (stop_seen) begin
            // stop ends, and mid-byte aborts, whatever was running [R3] [R20] [R18]
            n.st = ST_IDLE;
            n.bit_cnt = 4'h0;
            n.sda_oe = 1'b0;
            n.ack_go = 1'b0;
        end else begin
            case (q.st)
                ST_ADDR, ST_WRX: begin
                    // sample on the rising clock, msb first [R2] [R4]
                    if (scl_rise && q.bit_cnt < `BYTE_BITS) begin
                        n.shift = {q.shift[6:0], sda_n}; // [R2]
                        n.bit_cnt = q.bit_cnt + 4'h1;
                    end
                    // decide the acknowledge once the eighth clock goes low
                    if (scl_fall && q.bit_cnt == `BYTE_BITS) begin
                        n.st = ST_ACK;
                        n.bump = 1'b0;
                        if (q.st == ST_ADDR) begin
                            n.addr_phase = 1'b1;
                            n.is_read = (q.shift[0] == `DIR_READ); // [R12]
                            n.ack_go = (q.shift[7:1] == `TARGET_ADDR7); // [R11] [R13]
                        end else if (!q.have_index) begin
                            // first byte of a write is the register index [R14]
                            n.addr_phase = 1'b0;
                            n.index = q.shift;
                            n.have_index = 1'b1;
                            n.ack_go = 1'b1;
                        end else begin
                            // full buffer refuses the byte with a nack
                            n.addr_phase = 1'b0;
                            n.ack_go = fifo_in_ready;
                            n.push = fifo_in_ready; // [R14]
                            n.push_data = {q.index, q.shift};
                            n.bump = fifo_in_ready;
                        end
                        n.sda_oe = n.ack_go; // hold low through the ninth clock [R8] [R9]
                    end
                end
                ST_ACK: begin
                    // ninth clock ends: release, then pick the next phase
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.bit_cnt = 4'h0;
                        if (q.bump) begin
                            n.index = q.index + 8'h01; // [R15]
                        end
                        if (!q.ack_go) begin
                            n.st = ST_IDLE; // unaddressed or refused byte: wait for a start
                        end else if (q.addr_phase && q.is_read) begin
                            // become transmitter, first bit driven now [R13] [R16]
                            n.st = ST_TX;
                            n.shift = I_RD_DATA;
                            n.sda_oe = !I_RD_DATA[7]; // [R2]
                        end else begin
                            n.st = ST_WRX; // [R13]
                        end
                    end
                end
                ST_TX: begin
                    // change data only after the clock has fallen [R2] [R4]
                    if (scl_fall) begin
                        if (q.bit_cnt == `TX_LAST_FALL) begin
                            n.sda_oe = 1'b0; // free the line for the master ack [R8]
                            n.st = ST_MACK;
                        end else begin
                            n.shift = {q.shift[6:0], 1'b0};
                            n.sda_oe = !q.shift[6];
                            n.bit_cnt = q.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // low in the ninth clock means send more [R10] [R17]
                    if (scl_rise) begin
                        n.ack_go = !sda_n;
                        if (!sda_n) begin
                            n.index = q.index + 8'h01; // [R17]
                        end
                    end
                    if (scl_fall) begin
                        n.bit_cnt = 4'h0;
                        if (q.ack_go) begin
                            n.st = ST_TX;
                            n.shift = I_RD_DATA; // [R17]
                            n.sda_oe = !I_RD_DATA[7];
                        end else begin
                            n.st = ST_IDLE; // nack: stay off the line [R18]
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                ST_IDLE: begin
                    // unaddressed or finished: keep off the line until a start
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.st = ST_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
        n.busy = (n.st != ST_IDLE);
    end

    // ==========================================
    // state register; lines idle high so filters start at one
    // enable low freezes every flop of the record, filters included
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.scl_sync <= 2'h3;
            q.sda_sync <= 2'h3;
            q.scl_hist <= '1;
            q.sda_hist <= '1;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.st <= ST_IDLE;
        end else if (I_CE) begin
            q <= n;
        end
    end

    // ==========================================
    // write data buffer towards the register file
    // words carry the index in the upper byte and the data in the lower
    // the consumer may stall; a full buffer makes the port refuse bytes
    byte_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_wr_fifo (
        .i_clk(I_MCLK),
        .i_rst_n(rst_n),
        .i_ce(I_CE),
        .i_in_valid(q.push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(q.push_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(I_WR_READY),
        .o_out_data(fifo_out_data)
    );

    // ==========================================
    // outputs, all straight from flops
    // the data pin value is a constant low; only its enable moves
    assign O_SDA_O = q.sda_o;
    assign O_SDA_OE = q.sda_oe;
    assign O_BUSY = q.busy;
    assign O_RD_INDEX = q.index;
    assign O_WR_VALID = fifo_out_valid;
    assign O_WR_INDEX = fifo_out_data[15:8];
    assign O_WR_DATA = fifo_out_data[7:0];
endmodule

// ==== backlight_i2c_slave_port_monitor.sv ====
// concurrent checks on the ports of the two-wire slave port
`timescale 1ns/1ps
module backlight_i2c_slave_port_monitor #(
    parameter int FIFO_W = 16,
    parameter int FIFO_D = 8
) (
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA_O,
    input wire logic O_SDA_OE,
    input wire logic O_WR_VALID,
    input wire logic I_WR_READY,
    input wire logic [7:0] O_WR_INDEX,
    input wire logic [7:0] O_WR_DATA,
    input wire logic [7:0] O_RD_INDEX,
    input wire logic [7:0] I_RD_DATA,
    input wire logic O_BUSY
);
    // ==========================================
    // one clock domain, checks idle during reset
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    a_sda_o_zero: assert property (!O_SDA_O)
        else $error("data output value not low");
    a_reset_quiet: assert property ($rose(I_RST_B) |-> !O_SDA_OE && !O_BUSY)
        else $error("line driven right after reset");
    a_idle_release: assert property (!O_BUSY && !$past(O_BUSY) |-> !O_SDA_OE)
        else $error("line driven while idle");
    a_start_busy: assert property ($fell(I_SDA) && I_SCL && $past(I_SCL) |-> ##[1:12] O_BUSY)
        else $error("start not taken");
    a_stop_idles: assert property ($rose(I_SDA) && I_SCL && $past(I_SCL) |-> ##[1:12] !O_BUSY)
        else $error("stop not taken");
    // the device only turns the line while the bus clock is low
    a_oe_clock_low: assert property ($changed(O_SDA_OE) |-> !I_SCL)
        else $error("data changed while clock high");
    a_drive_holds: assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*8])
        else $error("driven bit too short");
    a_wr_hold: assert property (O_WR_VALID && !I_WR_READY |=> O_WR_VALID
        && $stable(O_WR_DATA) && $stable(O_WR_INDEX))
        else $error("write word dropped while stalled");
    a_index_busy: assert property ($changed(O_RD_INDEX) |-> O_BUSY)
        else $error("index moved outside a transfer");
endmodule

bind backlight_i2c_slave_port backlight_i2c_slave_port_monitor #(
    .FIFO_W(FIFO_W), .FIFO_D(FIFO_D)) i_monitor (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
    .I_CE(I_CE), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_O(O_SDA_O), .O_SDA_OE(O_SDA_OE),
    .O_WR_VALID(O_WR_VALID), .I_WR_READY(I_WR_READY), .O_WR_INDEX(O_WR_INDEX),
    .O_WR_DATA(O_WR_DATA), .O_RD_INDEX(O_RD_INDEX), .I_RD_DATA(I_RD_DATA), .O_BUSY(O_BUSY));

// ==== i2c_master_model.sv ====
// bus master model driving clock and open-drain data of the slave port
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // ==========================================
    // clock stands high between frames, data released
    logic framed = 1'b0;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // low phase stretched so the filtered device can turn the line round in time
    task automatic put_bit(input logic b, output logic s);
        o_scl <= 1'b0;
        tick(5);
        o_sda_low <= ~b; // data moves only while clock low
        tick(5);
        o_scl <= 1'b1;
        tick(4);
        s = i_sda; // sampled at end of high phase
    endtask

    task automatic start();
        if (framed) begin
            o_scl <= 1'b0;
            tick(5);
        end
        o_sda_low <= 1'b0;
        tick(5);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b1;
        tick(4);
        framed = 1'b1;
    endtask

    task automatic stop();
        o_scl <= 1'b0;
        tick(5);
        o_sda_low <= 1'b1;
        tick(5);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b0;
        tick(10);
        framed = 1'b0;
    endtask

    // eight bits msb first, then a released ninth clock for the device's answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(last, s); // high on the last byte
    endtask
endmodule

// ==== backlight_i2c_slave_port_test.sv ====
// self-checking bench of the two-wire slave port
`timescale 1ns/1ps
module backlight_i2c_slave_port_test;
    // ==========================================
    // clock, wires and stand-ins for the register side
    logic mclk = 1'b0;
    logic rst_b, ce, scl, sda, m_low, sda_o, sda_oe, wr_valid, wr_ready, busy;
    logic [7:0] wr_index, wr_data, rd_index;
    logic [7:0] rd_data = 8'h00;
    int errors = 0;
    int comparisons = 0;
    always #12.5 mclk = ~mclk;
    assign sda = ~(sda_oe | m_low); // open drain with pull-up
    // register content is a fixed function of its index, one cycle late
    always @(posedge mclk) rd_data <= rd_index ^ 8'h5c;

    i2c_master_model i_master (.i_clk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
    backlight_i2c_slave_port #(.FIFO_W(16), .FIFO_D(8)) i_dut (.I_MCLK(mclk),
        .I_RST_B(rst_b), .I_CE(ce), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(sda_o),
        .O_SDA_OE(sda_oe), .O_WR_VALID(wr_valid), .I_WR_READY(wr_ready),
        .O_WR_INDEX(wr_index), .O_WR_DATA(wr_data), .O_RD_INDEX(rd_index),
        .I_RD_DATA(rd_data), .O_BUSY(busy));

    // ==========================================
    // comparison, byte send with answer check, verdict
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send_chk(input logic [7:0] b, input logic exp_ack);
        logic ack;
        i_master.send_byte(b, ack);
        check8({7'h00, ack}, {7'h00, exp_ack});
    endtask

    task automatic close_out();
        $display("comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_write_full();
        logic ack;
        int n;
        i_master.start();
        send_chk(8'h58, 1'b1);
        send_chk(8'hfe, 1'b1);
        for (int i = 0; i < 10; i++) begin
            i_master.send_byte(8'h40 + i[7:0], ack);
            check8({7'h00, ack}, {7'h00, i < 9});
        end
        i_master.stop();
        wr_ready <= 1'b1;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge mclk);
            if (wr_valid === 1'b1) begin
                check8(wr_index, 8'hfe + n[7:0]); // index wraps past ff
                check8(wr_data, 8'h40 + n[7:0]);
                n++;
            end
        end
        wr_ready <= 1'b0;
        check8(n[7:0], 8'h09); // eight queued plus head word
    endtask

    task automatic t_reset_mid();
        i_master.start();
        send_chk(8'h58, 1'b1);
        ce <= 1'b0;
        repeat (20) @(posedge mclk);
        check8({7'h00, busy}, 8'h01); // enable low freezes the byte state
        ce <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        check8({6'h00, sda_oe, busy}, 8'h00);
        rst_b <= 1'b1;
        repeat (10) @(posedge mclk);
        i_master.stop();
        check8({6'h00, sda_oe, busy}, 8'h00);
        i_master.start();
        send_chk(8'h58, 1'b1); // fresh address after mid-run reset
        i_master.stop();
    endtask

    task automatic t_bad_addr();
        logic [7:0] wrong [3] = '{8'h5a, 8'hd8, 8'h2c};
        for (int i = 0; i < 3; i++) begin
            i_master.start();
            send_chk(wrong[i], 1'b0);
        end
        i_master.stop();
        check8({6'h00, sda_oe, busy}, 8'h00);
    endtask

    task automatic t_read();
        logic [7:0] b;
        i_master.start();
        send_chk(8'h58, 1'b1);
        send_chk(8'h10, 1'b1);
        i_master.start();
        send_chk(8'h59, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_master.recv_byte(i == 2, b);
            check8(b, (8'h10 + i[7:0]) ^ 8'h5c);
        end
        i_master.stop();
        check8(rd_index, 8'h12); // no step on the final nack
        check8({6'h00, sda_oe, busy}, 8'h00);
    endtask

    task automatic t_abort();
        logic s;
        i_master.start();
        for (int i = 0; i < 3; i++) i_master.put_bit(1'b0, s);
        i_master.stop();
        check8({7'h00, busy}, 8'h00);
        i_master.start();
        i_master.put_bit(1'b1, s);
        i_master.start();
        send_chk(8'h58, 1'b1); // fresh address after mid-byte start
        i_master.stop();
    endtask

    // ==========================================
    // main sequence: reset, then every scenario once
    initial begin
        rst_b <= 1'b0;
        ce <= 1'b1;
        wr_ready <= 1'b0;
        repeat (10) @(posedge mclk);
        check8({5'h00, sda_o, sda_oe, wr_valid}, 8'h00);
        rst_b <= 1'b1;
        repeat (10) @(posedge mclk);
        t_write_full();
        t_bad_addr();
        t_read();
        t_abort();
        t_reset_mid();
        close_out();
    end
endmodule
